// ==== inc/xcf_defines.svh ====
`ifndef XCF_DEFINES_SVH
`define XCF_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses in configuration space)
// ----------------------------------------------------------------
`define XCF_ADDR_W            12
`define XCF_OFF_TARGET        12'h0a0
`define XCF_OFF_PAYLOAD       12'h0a4
`define XCF_OFF_RESULT        12'h0a8

// ----------------------------------------------------------------
// result register field positions
// ----------------------------------------------------------------
`define XCF_RES_BUSY_BIT      0
`define XCF_RES_DONE_BIT      1
`define XCF_RES_STATUS_LO     2
`define XCF_RES_STATUS_HI     4
`define XCF_RES_ABORTED_BIT   5
`define XCF_RES_CAPABLE_BIT   31

// ----------------------------------------------------------------
// target register writable bits, reset values
// ----------------------------------------------------------------
`define XCF_TARGET_WR_MASK    32'hcffffffc
`define XCF_TARGET_RESET      32'h0000_0000
`define XCF_PAYLOAD_RESET     32'h0000_0000
`define XCF_CAPABLE_DEFAULT   1'h1

// ----------------------------------------------------------------
// completion status codes
// ----------------------------------------------------------------
`define XCF_ST_SUCCESS        3'h0
`define XCF_ST_UNSUPPORTED    3'h1
`define XCF_ST_RETRY          3'h2
`define XCF_ST_COMPL_ABORT    3'h3
`define XCF_ST_REQ_ABORT      3'h4

`endif

// ==== inc/xcf_pkg.sv ====
package xcf_pkg;

    // control register image, msb first
    typedef struct packed {
        logic       accessDirection;
        logic       configAccessKind;
        logic [1:0] rsvdHi;
        logic [7:0] targetBusNumber;
        logic [4:0] targetSlotNumber;
        logic [2:0] targetFnNumber;
        logic [3:0] targetExtWordIndex;
        logic [5:0] targetWordIndex;
        logic [1:0] rsvdLo;
    } xcf_target_type;

    // register access from the configuration space decoder
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
        logic [3:0]  byteEn;
        logic [31:0] wdata;
    } xcf_reg_req_type;

    // configuration request toward the far side of the bridge
    typedef struct packed {
        logic [7:0]  busNumber;
        logic [4:0]  slotNumber;
        logic [2:0]  fnNumber;
        logic [3:0]  extWordIndex;
        logic [5:0]  wordIndex;
        logic        kindType1;
        logic        isWrite;
        logic [3:0]  byteEn;
        logic [31:0] data;
    } xcf_far_req_type;

    // completion returned from the far side
    typedef struct packed {
        logic [2:0]  status;
        logic [31:0] data;
    } xcf_far_cpl_type;

    typedef enum logic [1:0] {
        XCF_IDLE,
        XCF_ISSUE,
        XCF_WAIT,
        XCF_DRAIN
    } xcf_phase_type;

endpackage

// ==== src/xcf_readback.sv ====
`timescale 1ns/100ps

`include "xcf_defines.svh"

// ----------------------------------------------------------------
// read-back multiplexer for the three forwarding registers
// ----------------------------------------------------------------
module xcf_readback #(
    parameter bit CAPABLE = `XCF_CAPABLE_DEFAULT
) (
    // lookup
    input  wire logic [11:0]             addr,
    // block state
    input  wire xcf_pkg::xcf_target_type target,
    input  wire logic [31:0]             payload,
    input  wire logic                    busy,
    input  wire logic                    done,
    input  wire logic [2:0]              status,
    input  wire logic                    aborted,
    // result
    output logic [31:0]                  rdValue
);

    logic [31:0] resultWord;

    always_comb begin
        resultWord = 32'h0000_0000;
        resultWord[`XCF_RES_BUSY_BIT] = busy;
        resultWord[`XCF_RES_DONE_BIT] = done;
        resultWord[`XCF_RES_STATUS_HI:`XCF_RES_STATUS_LO] = status;
        resultWord[`XCF_RES_ABORTED_BIT] = aborted;
        resultWord[`XCF_RES_CAPABLE_BIT] = CAPABLE;
    end

    always_comb begin
        rdValue = 32'h0000_0000;
        // without the feature everything reads zero
        if (CAPABLE) begin
            case (addr)
                `XCF_OFF_TARGET:  rdValue = target & `XCF_TARGET_WR_MASK;
                `XCF_OFF_PAYLOAD: rdValue = payload;
                `XCF_OFF_RESULT:  rdValue = resultWord;
                default:          rdValue = 32'h0000_0000;
            endcase
        end
    end

endmodule

// ==== src/xcf_config_forwarder.sv ====
`timescale 1ns/100ps

`include "xcf_defines.svh"

// How it works
// - function field goes into request function
// - slot field goes into request device
// - bus field goes into request bus
// - word and extended index form address
// - kind bit picks type 0 or 1
// - direction bit picks read or write
// - each payload write while not busy launches one transaction
// - write byte enables copied to request
// - write payload sent as request data
// - read ignores data, returns value later
// - busy high while transaction in progress
// - done set on completion, status valid
// - writing one clears done, aborts flight
// - status field holds last completion result
// - status codes zero through four defined
// - aborted flag holds until next launch
// - capability bit reads one when supported
// - unsupported build reads all fields zero
// - sticky fields survive hot reset
module xcf_config_forwarder #(
    parameter bit CAPABLE = `XCF_CAPABLE_DEFAULT
) (
    // clock and resets
    input  wire logic                     mclk,
    input  wire logic                     rst,
    input  wire logic                     porRst,
    input  wire logic                     ce,
    // configuration register access
    input  wire xcf_pkg::xcf_reg_req_type regReq,
    output logic                          rdValid,
    output logic [31:0]                   rdData,
    // request toward far side
    output logic                          reqValid,
    input  wire logic                     reqReady,
    output xcf_pkg::xcf_far_req_type      req,
    // completion from far side
    input  wire logic                     cplValid,
    input  wire xcf_pkg::xcf_far_cpl_type cpl,
    // status
    output logic                          busy
);

    typedef struct packed {
        xcf_pkg::xcf_phase_type   phase;
        xcf_pkg::xcf_target_type  target;
        logic [31:0]              payload;
        logic                     done;
        logic                     aborted;
        logic [2:0]               status;
        logic                     pending;
        xcf_pkg::xcf_far_req_type req;
        logic                     rdValid;
        logic [31:0]              rdData;
    } xcf_core_type;

    xcf_core_type cur_r;
    xcf_core_type cur_nxt;
    xcf_core_type hotVal;

    logic [31:0] byteMask;
    logic [31:0] rdValue;
    logic        busyNow;
    logic        wrTarget;
    logic        wrPayload;
    logic        wrResult;
    logic        trig;
    logic        abortReq;
    logic        cplTaken;
    logic        reqTaken;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign byteMask[gi*8 +: 8] = {8{regReq.byteEn[gi]}};
        end
    endgenerate

    // busy covers issue, wait and a launch queued behind a drain
    assign busyNow = (cur_r.phase == xcf_pkg::XCF_ISSUE)
                   || (cur_r.phase == xcf_pkg::XCF_WAIT) || cur_r.pending;
    assign wrTarget  = regReq.valid && regReq.write && (regReq.addr == `XCF_OFF_TARGET);
    assign wrPayload = regReq.valid && regReq.write && (regReq.addr == `XCF_OFF_PAYLOAD);
    assign wrResult  = regReq.valid && regReq.write && (regReq.addr == `XCF_OFF_RESULT);
    // a payload write while not busy (idle or drain) is a launch; while busy it is refused
    assign trig      = CAPABLE && wrPayload && !busyNow;
    // one to done while busy aborts the operation
    assign abortReq  = CAPABLE && wrResult && regReq.byteEn[0]
                     && regReq.wdata[`XCF_RES_DONE_BIT] && busyNow;
    assign cplTaken  = cplValid && (cur_r.phase == xcf_pkg::XCF_WAIT);
    assign reqTaken  = reqValid && reqReady;

    xcf_readback #(
        .CAPABLE (CAPABLE)
    ) u_readback (
        .addr    (regReq.addr),
        .target  (cur_r.target),
        .payload (cur_r.payload),
        .busy    (busyNow),
        .done    (cur_r.done),
        .status  (cur_r.status),
        .aborted (cur_r.aborted),
        .rdValue (rdValue)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        cur_nxt.rdValid = 1'b0;
        if (regReq.valid && !regReq.write) begin
            cur_nxt.rdValid = 1'b1;
            cur_nxt.rdData  = rdValue;
        end

        // target fields written under byte enables
        if (CAPABLE && wrTarget) begin
            cur_nxt.target = (cur_r.target & ~(byteMask & `XCF_TARGET_WR_MASK))
                           | (regReq.wdata & byteMask & `XCF_TARGET_WR_MASK);
        end

        // write one to done clears it
        if (wrResult && regReq.byteEn[0] && regReq.wdata[`XCF_RES_DONE_BIT]) begin
            cur_nxt.done = 1'b0;
        end

        // abort drops the request or discards its completion later
        if (abortReq) begin
            cur_nxt.status  = `XCF_ST_REQ_ABORT;
            cur_nxt.aborted = 1'b1;
            cur_nxt.pending = 1'b0;
            if (cur_r.phase == xcf_pkg::XCF_ISSUE && !reqReady) begin
                cur_nxt.phase = xcf_pkg::XCF_IDLE;
            end else if (cur_r.phase != xcf_pkg::XCF_IDLE) begin
                cur_nxt.phase = xcf_pkg::XCF_DRAIN;
            end
        end

        // snapshot the request at the launching write
        if (trig) begin
            cur_nxt.done             = 1'b0;
            // aborted flag cleared by the next launch
            cur_nxt.aborted          = 1'b0;
            cur_nxt.req.fnNumber     = cur_r.target.targetFnNumber;
            cur_nxt.req.slotNumber   = cur_r.target.targetSlotNumber;
            cur_nxt.req.busNumber    = cur_r.target.targetBusNumber;
            cur_nxt.req.wordIndex    = cur_r.target.targetWordIndex;
            cur_nxt.req.extWordIndex = cur_r.target.targetExtWordIndex;
            cur_nxt.req.kindType1    = cur_r.target.configAccessKind;
            cur_nxt.req.isWrite      = cur_r.target.accessDirection;
            cur_nxt.req.byteEn       = regReq.byteEn;
            cur_nxt.req.data         = cur_r.target.accessDirection ? regReq.wdata
                                                                    : 32'h0000_0000;
            // a read leaves the payload register alone
            if (cur_r.target.accessDirection) begin
                cur_nxt.payload = (cur_r.payload & ~byteMask) | (regReq.wdata & byteMask);
            end
            if (cur_r.phase == xcf_pkg::XCF_DRAIN) begin
                cur_nxt.pending = 1'b1;
            end else begin
                cur_nxt.phase = xcf_pkg::XCF_ISSUE;
            end
        end

        case (cur_r.phase)
            xcf_pkg::XCF_IDLE: begin
            end
            xcf_pkg::XCF_ISSUE: begin
                if (reqTaken && !abortReq) begin
                    cur_nxt.phase = xcf_pkg::XCF_WAIT;
                end
            end
            xcf_pkg::XCF_WAIT: begin
                // completion ends the transaction; set wins over clear
                if (cplValid) begin
                    cur_nxt.phase   = xcf_pkg::XCF_IDLE;
                    cur_nxt.done    = 1'b1;
                    cur_nxt.status  = cpl.status;
                    cur_nxt.aborted = (cpl.status == `XCF_ST_REQ_ABORT);
                    cur_nxt.pending = 1'b0;
                    // read data lands in the payload register
                    if (!cur_r.req.isWrite) begin
                        cur_nxt.payload = cpl.data;
                    end
                end
            end
            xcf_pkg::XCF_DRAIN: begin
                // stale completion of an aborted request is thrown away
                if (cplValid) begin
                    cur_nxt.phase   = (cur_nxt.pending) ? xcf_pkg::XCF_ISSUE
                                                        : xcf_pkg::XCF_IDLE;
                    cur_nxt.pending = 1'b0;
                end
            end
            default: begin
                cur_nxt.phase = xcf_pkg::XCF_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // hot reset image
    // ----------------------------------------------------------------
    // sticky fields kept, the rest returns to defaults
    always_comb begin
        hotVal = '0;
        hotVal.target                 = cur_r.target;
        hotVal.target.configAccessKind = 1'b0;
        hotVal.payload                = cur_r.payload;
        hotVal.done                   = cur_r.done;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (porRst) begin
            cur_r <= '0;
        end else if (rst) begin
            cur_r <= hotVal;
        end else if (ce) begin
            cur_r <= cur_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reqValid = (cur_r.phase == xcf_pkg::XCF_ISSUE);
    assign req      = cur_r.req;
    assign rdValid  = cur_r.rdValid;
    assign rdData   = cur_r.rdData;
    assign busy     = busyNow;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || porRst);

    sequence seqLaunch;
        ce && trig ##1 reqValid && busy && !cur_r.done;
    endsequence

    sequence seqComplete;
        ce && cplTaken ##1 cur_r.done && !busy;
    endsequence

    // a launch queued behind a drain raises the request later, so it is left out here
    AST_LAUNCH: assert property (ce && trig && (cur_r.phase != xcf_pkg::XCF_DRAIN)
        |-> seqLaunch)
        else $error("launch did not raise the request");
    AST_BUSY_DONE: assert property (ce && trig |=> busy && !cur_r.done)
        else $error("launch did not set busy and clear done");
    // target may be rewritten while busy, so compare against the launch snapshot
    AST_REQ_ADDR: assert property (ce && trig
        |=> req.fnNumber == $past(cur_r.target.targetFnNumber)
        && req.slotNumber == $past(cur_r.target.targetSlotNumber)
        && req.busNumber == $past(cur_r.target.targetBusNumber)
        && req.extWordIndex == $past(cur_r.target.targetExtWordIndex)
        && req.wordIndex == $past(cur_r.target.targetWordIndex))
        else $error("request address differs from target fields");
    AST_REQ_KIND: assert property (ce && trig |=> req.kindType1 == $past(cur_r.target.configAccessKind))
        else $error("request type does not follow kind bit");
    AST_REQ_DIR: assert property (ce && trig |=> req.isWrite == $past(cur_r.target.accessDirection))
        else $error("request direction does not follow direction bit");
    AST_REQ_BE: assert property (ce && trig |=> req.byteEn == $past(regReq.byteEn))
        else $error("request byte enables differ from the write");
    AST_WR_DATA: assert property (ce && trig && cur_r.target.accessDirection
        |=> req.data == $past(regReq.wdata))
        else $error("write payload not carried in request");
    AST_RD_RETURN: assert property (ce && cplTaken && !cur_r.req.isWrite
        |=> cur_r.payload == $past(cpl.data))
        else $error("read data not placed in payload register");
    AST_DONE_SET: assert property (ce && cplTaken |-> seqComplete)
        else $error("completion did not set done");
    AST_ABORT: assert property (ce && abortReq && !cplTaken
        |=> !busy && cur_r.aborted && cur_r.status == `XCF_ST_REQ_ABORT)
        else $error("abort did not end the operation");
    AST_ABORT_HOLD: assert property (cur_r.aborted && !(ce && trig) |=> cur_r.aborted)
        else $error("aborted flag dropped before next launch");
    AST_STICKY: assert property (disable iff (porRst) rst |=> cur_r.payload == $past(cur_r.payload)
        && cur_r.done == $past(cur_r.done))
        else $error("sticky fields lost on hot reset");

endmodule

// ==== sim/xcf_far_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------------------------------
// configuration space beyond the bridge
// ----------------------------------------------------------------
module xcf_far_model (
    // clock
    input  wire logic                     mclk,
    // request from the forwarder
    input  wire logic                     reqValid,
    output logic                          reqReady,
    input  wire xcf_pkg::xcf_far_req_type req,
    // completion back
    output logic                          cplValid,
    output xcf_pkg::xcf_far_cpl_type      cpl,
    // pacing and answer chosen by the bench
    input  wire logic [7:0]               readyDelay,
    input  wire logic [7:0]               cplDelay,
    input  wire logic [2:0]               cplStatus
);
    xcf_pkg::xcf_far_req_type lastReq;
    logic [31:0]              mem [64];
    int                       nReq;
    int                       i;

    initial begin
        reqReady = 1'b0;
        cplValid = 1'b0;
        cpl      = '0;
        nReq     = 0;
        lastReq  = '0;
        for (i = 0; i < 64; i++) begin
            mem[i] = 32'h0;
        end
        forever begin
            @(negedge mclk);
            if (reqValid === 1'b1) begin
                // a pending request may still be withdrawn by an abort
                i = 0;
                while (i < readyDelay && reqValid === 1'b1) begin
                    @(negedge mclk);
                    i++;
                end
                if (reqValid === 1'b1) begin
                    reqReady = 1'b1;
                    lastReq  = req;
                    nReq++;
                    @(negedge mclk);
                    reqReady = 1'b0;
                    if (lastReq.isWrite) begin
                        mem[lastReq.wordIndex] = lastReq.data;
                    end
                    repeat (cplDelay) @(negedge mclk);
                    cpl.status = cplStatus;
                    cpl.data = lastReq.isWrite ? 32'h0 : mem[lastReq.wordIndex];
                    cplValid = 1'b1;
                    @(negedge mclk);
                    cplValid = 1'b0;
                    // stale data must not look valid
                    cpl.data = ~cpl.data;
                end
            end
        end
    end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps

module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic                     mclk;
    logic                     rst;
    logic                     porRst;
    logic                     ce;
    xcf_pkg::xcf_reg_req_type regReq;
    logic                     rdValid;
    logic [31:0]              rdData;
    logic                     rdValid0;
    logic [31:0]              rdData0;
    logic                     reqValid;
    logic                     reqReady;
    xcf_pkg::xcf_far_req_type req;
    logic                     cplValid;
    xcf_pkg::xcf_far_cpl_type cpl;
    logic                     busy;
    logic [7:0]               readyDelay;
    logic [7:0]               cplDelay;
    logic [2:0]               cplStatus;
    logic [31:0]              rd;
    logic [31:0]              rd0;
    int                       n_fail;
    int                       comparisons;

    xcf_config_forwarder DUT (.mclk(mclk), .rst(rst), .porRst(porRst), .ce(ce),
        .regReq(regReq), .rdValid(rdValid), .rdData(rdData), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .cplValid(cplValid), .cpl(cpl), .busy(busy));
    // build without the feature, sharing the register bus
    xcf_config_forwarder #(.CAPABLE(1'b0)) DUT0 (.mclk(mclk), .rst(rst), .porRst(porRst),
        .ce(ce), .regReq(regReq), .rdValid(rdValid0), .rdData(rdData0), .reqValid(),
        .reqReady(1'b0), .req(), .cplValid(1'b0), .cpl('0), .busy());
    xcf_far_model far (.mclk(mclk), .reqValid(reqValid), .reqReady(reqReady), .req(req),
        .cplValid(cplValid), .cpl(cpl), .readyDelay(readyDelay), .cplDelay(cplDelay),
        .cplStatus(cplStatus));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        if (n_fail == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        regReq = '{valid: 1'b1, write: 1'b1, addr: a, byteEn: be, wdata: d};
        @(negedge mclk);
        regReq.valid = 1'b0;
    endtask

    task automatic reg_rd(input logic [11:0] a, output logic [31:0] d, output logic [31:0] d0);
        @(negedge mclk);
        regReq = '{valid: 1'b1, write: 1'b0, addr: a, byteEn: 4'hf, wdata: 32'h0};
        @(negedge mclk);
        regReq.valid = 1'b0;
        chk({31'h0, rdValid}, 32'h1, "no read answer");
        d  = rdData;
        d0 = rdData0;
    endtask

    function automatic logic [31:0] tgtOf(input logic dir, input logic kind,
            input logic [7:0] bus, input logic [4:0] slot, input logic [2:0] fn,
            input logic [3:0] ext, input logic [5:0] word);
        return {dir, kind, 2'h0, bus, slot, fn, ext, word, 2'h0};
    endfunction

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        chk({31'h0, busy}, 32'h0, "busy stuck");
    endtask

    task automatic xfer(input logic dir, input logic kind, input logic [7:0] bus,
            input logic [4:0] slot, input logic [2:0] fn, input logic [3:0] ext,
            input logic [5:0] word, input logic [3:0] be, input logic [31:0] d,
            input logic [2:0] st);
        int n0;
        reg_wr(12'h0a0, 4'hf, tgtOf(dir, kind, bus, slot, fn, ext, word));
        cplStatus = st;
        n0 = far.nReq;
        reg_wr(12'h0a4, be, d);
        chk({31'h0, busy}, 32'h1, "busy after launch");
        reg_rd(12'h0a8, rd, rd0);
        chk(rd & 32'h3, 32'h1, "busy/done in flight");
        wait_idle();
        chk(far.nReq, n0 + 1, "transaction count");
        chk({far.lastReq.busNumber, far.lastReq.slotNumber, far.lastReq.fnNumber,
            far.lastReq.extWordIndex, far.lastReq.wordIndex},
            {bus, slot, fn, ext, word}, "target fields");
        chk({far.lastReq.kindType1, far.lastReq.isWrite, far.lastReq.byteEn},
            {kind, dir, be}, "kind/dir/be");
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        // writes with the clock enable low must leave everything untouched
        ce = 1'b0;
        reg_wr(12'h0a0, 4'hf, 32'hffff_ffff);
        reg_wr(12'h0a4, 4'hf, 32'h1234_5678);
        ce = 1'b1;
        chk({31'h0, busy}, 32'h0, "launch while frozen");
        chk(far.nReq, 0, "request while frozen");
        reg_rd(12'h0a0, rd, rd0);
        chk(rd, 32'h0, "target reset");
        reg_rd(12'h0a4, rd, rd0);
        chk(rd, 32'h0, "payload reset");
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0000, "result reset");
        chk(rd0, 32'h0, "result unsupported");
        reg_rd(12'h0ac, rd, rd0);
        chk(rd, 32'h0, "unmapped read");
        reg_wr(12'h0a0, 4'hf, 32'hffff_ffff);
        reg_wr(12'h0a0, 4'h2, 32'h0);
        reg_rd(12'h0a0, rd, rd0);
        chk(rd, 32'hcfff_00fc, "target lanes/reserved");
        chk(rd0, 32'h0, "target unsupported");
    endtask

    task automatic t_xfer;
        logic [2:0] s;
        for (int k = 0; k < 5; k++) begin
            s = k;
            xfer(1'b1, s[0], 8'ha0 + s, 5'h11 + s, s, 4'hc - s, 6'h20 + s,
                4'h1 | (4'h1 << s[1:0]), 32'h1000_0001 * (k + 1), s);
            chk(far.lastReq.data, 32'h1000_0001 * (k + 1), "write payload");
            reg_rd(12'h0a8, rd, rd0);
            chk(rd & 32'hffff_ffdf, 32'h8000_0002 | (s << 2), "status");
        end
    endtask

    task automatic t_read;
        xfer(1'b0, 1'b0, 8'h3c, 5'h07, 3'h2, 4'h1, 6'h22, 4'hf, 32'hdead_beef, 3'h0);
        chk(far.lastReq.data, 32'h0, "read ignores data");
        reg_rd(12'h0a4, rd, rd0);
        chk(rd, 32'h3000_0003, "read value");
    endtask

    task automatic t_abort;
        int n0;
        readyDelay = 8'd30;
        n0 = far.nReq;
        reg_wr(12'h0a0, 4'hf, tgtOf(1'b1, 1'b0, 8'h01, 5'h02, 3'h3, 4'h4, 6'h05));
        reg_wr(12'h0a4, 4'hf, 32'h5555_aaaa);
        reg_wr(12'h0a8, 4'h1, 32'h2);
        chk({31'h0, busy}, 32'h0, "abort busy");
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0030, "abort result");
        chk(far.nReq, n0, "aborted not sent");
        readyDelay = 8'd1;
        xfer(1'b1, 1'b0, 8'h01, 5'h02, 3'h3, 4'h4, 6'h05, 4'hf, 32'h1, 3'h0);
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0002, "abort flag cleared");
        reg_wr(12'h0a8, 4'h1, 32'h2);
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0000, "done cleared");
        // abort in the cycle the far side takes the request: its completion is dropped
        reg_wr(12'h0a4, 4'hf, 32'h0);
        reg_wr(12'h0a8, 4'h1, 32'h2);
        chk({31'h0, busy}, 32'h0, "abort accepted busy");
        repeat (8) @(negedge mclk);
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0030, "stale completion dropped");
    endtask

    task automatic t_hot;
        xfer(1'b1, 1'b1, 8'h5a, 5'h1e, 3'h6, 4'h9, 6'h3f, 4'hf, 32'hc0de_0042, 3'h3);
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        reg_rd(12'h0a0, rd, rd0);
        chk(rd, tgtOf(1'b1, 1'b0, 8'h5a, 5'h1e, 3'h6, 4'h9, 6'h3f), "sticky target");
        reg_rd(12'h0a4, rd, rd0);
        chk(rd, 32'hc0de_0042, "sticky payload");
        reg_rd(12'h0a8, rd, rd0);
        chk(rd, 32'h8000_0002, "sticky done");
    endtask

    // ------------------------------------------------------------
    // clock, sequence, watchdog
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    initial begin
        n_fail      = 0;
        comparisons = 0;
        ce          = 1'b1;
        rst         = 1'b1;
        porRst      = 1'b1;
        regReq      = '0;
        readyDelay  = 8'd2;
        cplDelay    = 8'd3;
        cplStatus   = 3'h0;
        repeat (6) @(negedge mclk);
        rst    = 1'b0;
        porRst = 1'b0;
        t_regs();
        t_xfer();
        t_read();
        t_abort();
        t_hot();
        tally_and_finish();
    end

    // whole run is under two hundred cycles
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end
endmodule
